// ### hdl/qawd_regs.svh
// register offsets, field positions, reset values and timing for the q&a checker
`ifndef QAWD_REGS_SVH
`define QAWD_REGS_SVH
`define QAWD_ADR_LSB 2
`define QAWD_ADR_MSB 3
`define QAWD_IDX_CTRL 2'h0
`define QAWD_IDX_WINLEN 2'h1
`define QAWD_IDX_ANSWER 2'h2
`define QAWD_IDX_STATUS 2'h3
`define QAWD_CTRL_EN_BIT 0
`define QAWD_CTRL_THR_LSB 1
`define QAWD_CTRL_THR_MSB 4
`define QAWD_CTRL_MODE_BIT 5
`define QAWD_THR_RST 4'h5
`define QAWD_Q_RST 4'h0
`define QAWD_POS_FIRST 2'b11
`define QAWD_POS_FINAL 2'b00
`define QAWD_CNT_ZERO 3'h0
`define QAWD_CNT_W1_FULL 3'h3
`define QAWD_TOTAL_ALL 3'h4
`define QAWD_FAIL_MAX 4'hF
`define QAWD_HALF_WIN_MS 30
`define QAWD_CLK_KHZ 100000
`endif

// ### hdl/qawd_pkg.sv
// types shared by the q&a watchdog answer checker
package qawd_pkg;
  typedef enum logic [2:0] {
    QAWD_IDLE = 3'b001,
    QAWD_WIN1 = 3'b010,
    QAWD_WIN2 = 3'b100
  } qawd_phase_e;

  typedef struct packed {
    logic answerModeSelect;
    logic [3:0] failureCountThreshold;
    logic enable;
  } qawd_ctrl_s;

  typedef struct packed {
    qawd_phase_e phase;
    logic [3:0] failureCount;
    logic watchdogErrorFlag;
    logic answerErrorFlag;
    logic [1:0] answerPositionCounter;
    logic [3:0] currentQuestionValue;
  } qawd_status_s;
endpackage

// ### hdl/qawd_answer_checker.sv
// answer checker of the question-and-answer watchdog, with wishbone registers
`timescale 1ns/1ps
`include "qawd_regs.svh"

module qawd_answer_checker #(
  parameter int WIN_W = 24,
  parameter logic [WIN_W-1:0] HALF_WIN_CYC = WIN_W'(`QAWD_HALF_WIN_MS * `QAWD_CLK_KHZ)
)(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // watchdog outcome
  output logic [3:0] questionValue,
  output logic cycleJudged,
  output logic failAction
);

  generate
    if (WIN_W < 8 || WIN_W > 32)
    begin : g_bad_width
      $error("qawd_answer_checker: WIN_W must be 8 to 32");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // table of {resp3, resp2, resp1, resp0} per question
  localparam logic [31:0] ANSWER_ROWS [16] = '{
    32'hFF0F_F000, 32'hB040_BF4F, 32'hE919_E616, 32'hA656_A959,
    32'h7585_7A8A, 32'h3ACA_35C5, 32'h6393_6C9C, 32'h2CDC_23D3,
    32'hD222_DD2D, 32'h9D6D_9262, 32'hC434_CB3B, 32'h8B7B_8474,
    32'h58A8_57A7, 32'h17E7_18E8, 32'h4EBE_41B1, 32'h01F1_0EFE
  };

  // position 11 picks the top byte, 00 the bottom one
  function automatic logic [7:0] expectedByte(input logic [3:0] q, input logic [1:0] pos);
    return ANSWER_ROWS[q][{pos, 3'b000} +: 8];
  endfunction

  // small question sequencer; zero never repeats itself
  function automatic logic [3:0] nextQuestion(input logic [3:0] q);
    return (q == 4'h0) ? 4'h1 : {q[2:0], q[3] ^ q[2]};
  endfunction

  function automatic logic [31:0] laneMerge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [31:0] m;
    for (int i = 0; i < 4; i++)
      m[i*8 +: 8] = sel[i] ? dat[i*8 +: 8] : old[i*8 +: 8];
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rstSync_reg;
  logic sysRstN;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync_reg <= 2'b00;
    end
    else
    begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end

  assign sysRstN = rstSync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave and configuration

  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  qawd_pkg::qawd_ctrl_s ctrl_reg, ctrl_next;
  logic [WIN_W-1:0] winLen_reg, winLen_next;
  qawd_pkg::qawd_status_s status;
  logic [1:0] regIdx;
  logic busReq, busWrite, answerWrite;
  logic [31:0] ctrlWord, mergedCtrl, mergedWin;

  assign regIdx = wb_adr_i[`QAWD_ADR_MSB:`QAWD_ADR_LSB];
  assign busReq = wb_cyc_i & wb_stb_i;
  // writes land on the edge where ack is seen, as the master samples it
  assign busWrite = busReq & wb_we_i & ack_reg;
  assign answerWrite = busWrite & (regIdx == `QAWD_IDX_ANSWER) & wb_sel_i[0];
  assign ctrlWord = 32'(ctrl_reg);
  assign mergedCtrl = laneMerge(ctrlWord, wb_dat_i, wb_sel_i);
  assign mergedWin = laneMerge(32'(winLen_reg), wb_dat_i, wb_sel_i);

  always_comb
  begin
    ack_next = busReq & ~ack_reg;
    dat_next = dat_reg;
    ctrl_next = ctrl_reg;
    winLen_next = winLen_reg;
    if (busReq & ~ack_reg)
    begin
      case (regIdx)
        `QAWD_IDX_CTRL: dat_next = ctrlWord;
        `QAWD_IDX_WINLEN: dat_next = 32'(winLen_reg);
        `QAWD_IDX_STATUS: dat_next = 32'(status);
        default: dat_next = 32'h0000_0000;
      endcase
    end
    if (busWrite & (regIdx == `QAWD_IDX_CTRL))
    begin
      ctrl_next = qawd_pkg::qawd_ctrl_s'(mergedCtrl[`QAWD_CTRL_MODE_BIT:0]);
    end
    if (busWrite & (regIdx == `QAWD_IDX_WINLEN))
    begin
      winLen_next = mergedWin[WIN_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge sysRstN)
  begin
    if (!sysRstN)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      ctrl_reg <= '{answerModeSelect: 1'b0, failureCountThreshold: `QAWD_THR_RST,
                    enable: 1'b0};
      winLen_reg <= HALF_WIN_CYC;
    end
    else
    begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      ctrl_reg <= ctrl_next;
      winLen_reg <= winLen_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // answer checking

  qawd_pkg::qawd_phase_e phase_reg, phase_next;
  logic [WIN_W-1:0] timer_reg, timer_next;
  logic [1:0] pos_reg, pos_next;
  logic [2:0] cnt1_reg, cnt1_next, cnt2_reg, cnt2_next;
  logic wrong_reg, wrong_next;
  logic [3:0] question_reg, question_next;
  logic [3:0] fail_reg, fail_next;
  logic aerr_reg, aerr_next, werr_reg, werr_next;
  logic failAct_reg, failAct_next, judged_reg, judged_next;
  logic hit, timerEnd, judge, good, judgeWrong;
  logic [2:0] total;

  assign hit = wb_dat_i[7:0] == expectedByte(question_reg, pos_reg);
  assign timerEnd = timer_reg >= winLen_reg - WIN_W'(1);
  assign total = cnt1_reg + cnt2_reg + 3'h1;

  always_comb
  begin
    phase_next = phase_reg;
    timer_next = timer_reg + WIN_W'(1);
    pos_next = pos_reg;
    cnt1_next = cnt1_reg;
    cnt2_next = cnt2_reg;
    wrong_next = wrong_reg;
    question_next = question_reg;
    fail_next = fail_reg;
    aerr_next = aerr_reg;
    werr_next = werr_reg;
    failAct_next = 1'b0;
    judged_next = 1'b0;
    judge = 1'b0;
    good = 1'b0;
    judgeWrong = wrong_reg;
    case (phase_reg)
      qawd_pkg::QAWD_IDLE:
      begin
        timer_next = '0;
        // held in idle by the disable override below
        phase_next = qawd_pkg::QAWD_WIN1;
      end
      qawd_pkg::QAWD_WIN1:
      begin
        if (timerEnd)
        begin
          phase_next = qawd_pkg::QAWD_WIN2;
          timer_next = '0;
        end
        if (answerWrite)
        begin
          pos_next = pos_reg - 2'b01;
          cnt1_next = cnt1_reg + 3'h1;
          wrong_next = wrong_reg | ~hit;
          // a fourth byte inside window one is always a failed cycle
          if (cnt1_reg == `QAWD_CNT_W1_FULL)
          begin
            judge = 1'b1;
            judgeWrong = wrong_reg | ~hit;
          end
        end
      end
      qawd_pkg::QAWD_WIN2:
      begin
        if (answerWrite)
        begin
          pos_next = pos_reg - 2'b01;
          cnt2_next = cnt2_reg + 3'h1;
          wrong_next = wrong_reg | ~hit;
          if (total == `QAWD_TOTAL_ALL)
          begin
            judge = 1'b1;
            judgeWrong = wrong_reg | ~hit;
            // window two byte passes the cycle only if window one got three
            good = (cnt1_reg == `QAWD_CNT_W1_FULL) & ~wrong_reg & hit;
          end
        end
        else if (timerEnd)
        begin
          // short answer count: fails at window end, flag shows any mismatch
          judge = 1'b1;
          judgeWrong = wrong_reg;
        end
      end
      default:
      begin
        phase_next = qawd_pkg::QAWD_IDLE;
      end
    endcase
    if (judge)
    begin
      phase_next = qawd_pkg::QAWD_WIN1;
      timer_next = '0;
      pos_next = `QAWD_POS_FIRST;
      cnt1_next = `QAWD_CNT_ZERO;
      cnt2_next = `QAWD_CNT_ZERO;
      wrong_next = 1'b0;
      judged_next = 1'b1;
      aerr_next = judgeWrong & ~good;
      werr_next = ~good;
      if (good)
      begin
        question_next = nextQuestion(question_reg);
        fail_next = (fail_reg != 4'h0) ? fail_reg - 4'h1 : fail_reg;
      end
      else
      begin
        // question stays, failures climb and saturate
        fail_next = (fail_reg != `QAWD_FAIL_MAX) ? fail_reg + 4'h1 : fail_reg;
        failAct_next = (ctrl_reg.failureCountThreshold != 4'h0) &&
                       (fail_next >= ctrl_reg.failureCountThreshold);
      end
    end
    if (!ctrl_reg.enable)
    begin
      phase_next = qawd_pkg::QAWD_IDLE;
      timer_next = '0;
      pos_next = `QAWD_POS_FIRST;
      cnt1_next = `QAWD_CNT_ZERO;
      cnt2_next = `QAWD_CNT_ZERO;
      wrong_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge sysRstN)
  begin
    if (!sysRstN)
    begin
      phase_reg <= qawd_pkg::QAWD_IDLE;
      timer_reg <= '0;
      pos_reg <= `QAWD_POS_FIRST;
      cnt1_reg <= `QAWD_CNT_ZERO;
      cnt2_reg <= `QAWD_CNT_ZERO;
      wrong_reg <= 1'b0;
      question_reg <= `QAWD_Q_RST;
      fail_reg <= 4'h0;
      aerr_reg <= 1'b0;
      werr_reg <= 1'b0;
      failAct_reg <= 1'b0;
      judged_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      timer_reg <= timer_next;
      pos_reg <= pos_next;
      cnt1_reg <= cnt1_next;
      cnt2_reg <= cnt2_next;
      wrong_reg <= wrong_next;
      question_reg <= question_next;
      fail_reg <= fail_next;
      aerr_reg <= aerr_next;
      werr_reg <= werr_next;
      failAct_reg <= failAct_next;
      judged_reg <= judged_next;
    end
  end

  // status word, rides the packed struct straight onto the bus
  assign status = '{phase: phase_reg, failureCount: fail_reg,
                    watchdogErrorFlag: werr_reg, answerErrorFlag: aerr_reg,
                    answerPositionCounter: pos_reg, currentQuestionValue: question_reg};

  assign questionValue = question_reg;
  assign cycleJudged = judged_reg;
  assign failAction = failAct_reg;

endmodule

// ### verif/qawd_answer_checker_monitor.sv
// port-level assertions for the q&a answer checker
`timescale 1ns/1ps
module qawd_answer_checker_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // watchdog outcome
  input wire logic [3:0] questionValue,
  input wire logic cycleJudged,
  input wire logic failAction
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_judge_spacing: assert property (cycleJudged |=> !cycleJudged [*2])
    else $error("judgments too close");
  a_fail_single: assert property (failAction |=> !failAction)
    else $error("failure action longer than one cycle");
  a_fail_on_judge: assert property (failAction |-> cycleJudged)
    else $error("failure action outside a judgment");
  a_question_on_judge: assert property ($changed(questionValue) |-> cycleJudged)
    else $error("question changed outside a judgment");
  a_question_next: assert property ($changed(questionValue) |->
    questionValue == (($past(questionValue) == 4'h0) ? 4'h1 :
    {$past(questionValue[2:0]), $past(questionValue[3] ^ questionValue[2])}))
    else $error("question stepped to a wrong value");
  c_judged: cover property (cycleJudged);
  c_fail: cover property (failAction);
  c_new_question: cover property ($changed(questionValue));
endmodule

bind qawd_answer_checker qawd_answer_checker_monitor i_mon (
  .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .questionValue(questionValue), .cycleJudged(cycleJudged),
  .failAction(failAction));

// ### verif/qawd_host_model.sv
// host side model: wishbone classic master issuing register accesses
`timescale 1ns/1ps
module qawd_host_model (
  // clock
  input wire logic core_clk,
  // wishbone master
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [3:0] adr,
  output logic [3:0] sel,
  output logic [31:0] datW,
  input wire logic [31:0] datR,
  input wire logic ack
);
  initial {cyc, stb, we, adr, sel, datW} = '0;
  // request held until ack is sampled; a lost ack is left to the bench watchdog
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    datW <= d;
    do
    begin
      @(posedge core_clk);
    end
    while (ack !== 1'b1);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
endmodule

// ### verif/qawd_answer_checker_bench.sv
// self-checking bench for the q&a answer checker
`timescale 1ns/1ps
module qawd_answer_checker_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic failSeen = 1'b0;
  logic cyc, stb, we, ack, judged, fail;
  logic [3:0] adr, sel, question;
  logic [31:0] datW, datR, st;
  int n_errors = 0;
  int check_count = 0;
  int expFail = 0;
  // answer rows of questions 0..2, first byte in the top lane
  logic [31:0] tbl [3] = '{32'hFF0F_F000, 32'hB040_BF4F, 32'hE919_E616};
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (fail === 1'b1) failSeen <= 1'b1;
  qawd_answer_checker #(.HALF_WIN_CYC(24'h28)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
    .questionValue(question), .cycleJudged(judged), .failAction(fail));
  qawd_host_model i_host (
    .core_clk(core_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .datW(datW), .datR(datR), .ack(ack));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [3:0] a);
    i_host.xfer(1'b0, a, 32'h0, st);
  endtask
  task automatic waitW2;
    int n;
    n = 0;
    rd(4'hC);
    while (st[14:12] !== 3'b100 && n < 100)
    begin
      rd(4'hC);
      n++;
    end
    check({29'h0, st[14:12]}, 32'h0000_0004);
  endtask
  task automatic waitJudge;
    int n;
    n = 0;
    while (judged !== 1'b1 && n < 300)
    begin
      @(posedge core_clk);
      n++;
    end
    check({31'h0, judged}, 32'h0000_0001);
  endtask
  // k1 bytes in window one, the next k2 in window two
  task automatic run(input logic [31:0] b, input int k1, input int k2);
    for (int i = 0; i < k1 + k2; i++)
    begin
      if (i == k1)
        waitW2();
      i_host.xfer(1'b1, 4'h8, {24'h0, b[31-8*i -: 8]}, st);
    end
    if (k1 + k2 < 4)
      waitJudge();
  endtask
  // failure count saturates at 15 upward and floors at 0 downward
  task automatic judge(input logic aerr, input logic werr, input logic [3:0] q);
    if (werr)
      expFail = (expFail < 15) ? expFail + 1 : 15;
    else
      expFail = (expFail > 0) ? expFail - 1 : 0;
    rd(4'hC);
    check(st, {17'h0, 3'b010, 4'(expFail), werr, aerr, 2'b11, q});
    check({28'h0, question}, {28'h0, q});
  endtask
  task automatic tGood(input int q, input logic [3:0] qn);
    run(tbl[q], 3, 1);
    judge(1'b0, 1'b0, qn);
  endtask
  task automatic tNoAnswer;
    run(32'h0, 0, 0);
    judge(1'b0, 1'b1, 4'h2);
    check({31'h0, failSeen}, 32'h0);
  endtask
  task automatic tLateFour;
    run(tbl[2], 0, 4);
    judge(1'b0, 1'b1, 4'h2);
  endtask
  task automatic tOneInW2;
    run({tbl[2][31:16], 16'h0}, 2, 1);
    judge(1'b1, 1'b1, 4'h2);
  endtask
  task automatic tTotalFour;
    run({tbl[2][31:24], 24'h0}, 1, 3);
    judge(1'b1, 1'b1, 4'h2);
  endtask
  task automatic tLateCorrect;
    run(tbl[2], 0, 3);
    judge(1'b0, 1'b1, 4'h2);
  endtask
  initial
  begin
    #100_000;
    n_errors++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(4'h0);
    check(st, 32'h0000_000A);
    rd(4'h4);
    check(st, 32'h0000_0028);
    rd(4'hC);
    check(st, 32'h0000_1030);
    i_host.xfer(1'b1, 4'h0, 32'h0000_0005, st);
    tGood(0, 4'h1);
    tGood(1, 4'h2);
    tNoAnswer();
    tLateFour();
    tOneInW2();
    tTotalFour();
    tLateCorrect();
    tGood(2, 4'h4);
    check({31'h0, failSeen}, 32'h1);
    summarize();
  end
endmodule
